// ==== sbc_timing_defines.svh ====
// timing constants, field positions and reset values for the sbc timing link
// assumes a 100 MHz core clock on both ends and an 8-bit serial command
//
// What this block does
// - sample command bits falling, shift reply rising
// - command delays count from bit eight fall
// - can normal mode within 10 us
// - can sleep mode within 10 us
// - chip select rise wakes stop within 15-90 us
// - host waits 90 us after select wake
// - host waits 20 us after wake pulse
// - host spaces same-register messages 25 us apart
// - hold reset low 12-18 ms or 3-4 ms
// - overcurrent wakes only after 40-75 us deglitch
// - dominant transmit times out after 200-520 us
// - four transmitter slew settings, three fastest
// - can bit rates 60 kbit/s to 1 Mbit/s
// - stop wake gives 7-13 us low interrupt
// - transmit low dominant, receive mirrors bus
// - state timers run from 100 kHz oscillator
`ifndef SBC_TIMING_DEFINES_SVH
`define SBC_TIMING_DEFINES_SVH

`define CLK_PERIOD_NS 10
// internal oscillator, 100 kHz
`define OSC_PERIOD_NS 10000
`define OSC_PERIOD_US 10
`define OSC_DIV_CYC (`OSC_PERIOD_NS / `CLK_PERIOD_NS)

// device timers, in oscillator ticks
`define CAN_MODE_MAX_US 10
`define CAN_MODE_TICKS (`CAN_MODE_MAX_US / `OSC_PERIOD_US)
`define WAKE_NOM_US 40
`define WAKE_TICKS (`WAKE_NOM_US / `OSC_PERIOD_US)
`define TURNAROUND_US 90
`define TURNAROUND_TICKS ((`TURNAROUND_US + `OSC_PERIOD_US - 1) / `OSC_PERIOD_US)
`define INT_PULSE_US 10
`define INT_PULSE_TICKS (`INT_PULSE_US / `OSC_PERIOD_US)
`define DEGLITCH_US 55
`define DEGLITCH_TICKS ((`DEGLITCH_US + `OSC_PERIOD_US - 1) / `OSC_PERIOD_US)
`define DOM_TIMEOUT_US 360
`define DOM_TIMEOUT_TICKS (`DOM_TIMEOUT_US / `OSC_PERIOD_US)
`define RESET_HOLD_US 15000
`define RESET_HOLD_TICKS (`RESET_HOLD_US / `OSC_PERIOD_US)
`define RESET_HOLD_SHORT_US 3500
`define RESET_HOLD_SHORT_TICKS (`RESET_HOLD_SHORT_US / `OSC_PERIOD_US)

// host waits, in core clock cycles (least times, rounded up)
`define HOST_WAKE_WAIT_US 90
`define HOST_WAKE_WAIT_CYC ((`HOST_WAKE_WAIT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOST_INT_WAIT_US 20
`define HOST_INT_WAIT_CYC ((`HOST_INT_WAIT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOST_MSG_GAP_US 25
`define HOST_MSG_GAP_CYC ((`HOST_MSG_GAP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// serial clock made by the host: 160 ns period
`define SCLK_PERIOD_NS 160
`define SCLK_HALF_CYC (`SCLK_PERIOD_NS / (2 * `CLK_PERIOD_NS))

// command byte: [7:6] address, [5:0] data
`define CMD_ADDR_MSB 7
`define CMD_ADDR_LSB 6
`define ADDR_CAN 2'h0
`define ADDR_STOP 2'h1
`define CAN_NORMAL_BIT 0
`define SLEW_LSB 1
`define SLEW_MSB 2
`define STOP_GO_BIT 0

// reset values
`define SLEW_RESET 2'h3
// {bus, overcurrent, txd, mosi, sclk, cs_n}
`define DEV_SYNC_RESET 6'h09
// {int_n, rxd, miso}
`define HOST_SYNC_RESET 3'h6

`endif

// ==== sbc_timing_pkg.sv ====
// types shared by both ends of the sbc timing link
// assumes nothing beyond a SystemVerilog compiler
package sbc_timing_pkg;
    typedef logic [1:0] slew_t;
    typedef enum logic [1:0] {
        MODE_RESET,
        MODE_NORMAL,
        MODE_STOP,
        MODE_WAKE
    } sbc_mode_t;
    typedef enum logic [1:0] {
        H_IDLE,
        H_WAKE,
        H_SHIFT,
        H_END
    } host_state_t;
endpackage

// ==== sbc_link_if.sv ====
// serial command port plus can logic pins between host and sbc
// assumes the bench joins both ends through one instance
interface sbc_link_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic txd;
    logic rxd;
    logic int_n;
    logic sys_rst_n;
    modport device (input cs_n, sclk, mosi, txd, output miso, rxd, int_n, sys_rst_n);
    modport host (output cs_n, sclk, mosi, txd, input miso, rxd, int_n, sys_rst_n);
endinterface

// ==== sbc_device.sv ====
// sbc end: serial slave, mode and wake timers, can transmit guard
// assumes all incoming link pins are asynchronous to clk and resynchronised here
`include "sbc_timing_defines.svh"

module sbc_device #(
    parameter int OSC_DIV = `OSC_DIV_CYC,
    parameter bit SHORT_RESET = 1'b0,
    parameter int RESET_TICKS = `RESET_HOLD_TICKS,
    parameter int RESET_SHORT_TICKS = `RESET_HOLD_SHORT_TICKS
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // host link
    sbc_link_if.device link,
    // analog side
    input wire logic vdd_overcurrent,
    input wire logic bus_dominant,
    output logic can_drive_dom,
    output logic can_normal,
    output sbc_timing_pkg::slew_t can_slew,
    output sbc_timing_pkg::sbc_mode_t mode
);
    import sbc_timing_pkg::*;

    localparam int HOLD = SHORT_RESET ? RESET_SHORT_TICKS : RESET_TICKS;

    if (OSC_DIV < 2 || OSC_DIV > 65535 || HOLD < 1 || HOLD > 65535) begin : g_bad_param
        $error("sbc_device: oscillator divider or reset hold out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [5:0] meta_q;
    logic [5:0] sync_q;
    logic [1:0] prev_q;
    logic cs_s, sclk_s, mosi_s, txd_s, oc_s, bus_s;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= `DEV_SYNC_RESET;
            sync_q <= `DEV_SYNC_RESET;
            prev_q <= 2'h1;
        end else if (clk_en) begin
            meta_q <= {bus_dominant, vdd_overcurrent, link.txd, link.mosi, link.sclk, link.cs_n};
            sync_q <= meta_q;
            prev_q <= {sync_q[1], sync_q[0]};
        end
    end

    assign cs_s = sync_q[0];
    assign sclk_s = sync_q[1];
    assign mosi_s = sync_q[2];
    assign txd_s = sync_q[3];
    assign oc_s = sync_q[4];
    assign bus_s = sync_q[5];

    logic sclk_fall, sclk_rise, cs_fall, cs_rise;
    assign sclk_fall = prev_q[1] & ~sclk_s & ~cs_s;
    assign sclk_rise = ~prev_q[1] & sclk_s & ~cs_s;
    assign cs_fall = prev_q[0] & ~cs_s;
    assign cs_rise = ~prev_q[0] & cs_s;

    ////////////////////////////////////////////////////////////////////////
    // internal oscillator; restarted at wake so wake timers start whole
    logic [15:0] osc_q;
    logic tick;
    logic wake_evt;
    assign tick = (osc_q == 16'(OSC_DIV - 1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_q <= 16'h0000;
        end else if (clk_en) begin
            if (wake_evt || tick) begin
                osc_q <= 16'h0000;
            end else begin
                osc_q <= osc_q + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial slave
    logic [3:0] bit_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic miso_q;
    logic cmd_done;
    logic accept;
    logic [7:0] cmd;
    logic [7:0] status;
    sbc_mode_t mode_q;
    logic [3:0] guard_q;
    logic sys_rst_n_q, can_normal_q, timeout_q;
    slew_t slew_q;

    assign cmd_done = sclk_fall & (bit_q == 4'h7);
    assign cmd = {rx_q[6:0], mosi_s};
    assign accept = cmd_done & (mode_q == MODE_NORMAL) & (guard_q == 4'h0);
    assign status = {sys_rst_n_q, can_normal_q, slew_q, mode_q == MODE_STOP,
                     guard_q != 4'h0, timeout_q, 1'b0};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_q <= 4'h0;
            rx_q <= 8'h00;
        end else if (clk_en) begin
            if (cs_s) begin
                bit_q <= 4'h0;
            end else if (sclk_fall) begin
                rx_q <= cmd;
                bit_q <= (bit_q == 4'h7) ? 4'h0 : bit_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_q <= 8'h00;
            miso_q <= 1'b0;
        end else if (clk_en) begin
            if (cs_fall) begin
                // first rise re-sends bit seven, the host samples it on the first fall
                miso_q <= status[7];
                tx_q <= status;
            end else if (sclk_rise) begin
                miso_q <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode sequencing, reset hold and wake
    logic [15:0] rst_cnt_q;
    logic [3:0] wake_cnt_q;
    logic [3:0] oc_cnt_q;
    logic stop_pend_q;
    logic oc_wake;

    // counting whole ticks while high gives 50 to 60 us of persistence
    assign oc_wake = oc_s & (oc_cnt_q >= 4'(`DEGLITCH_TICKS));
    assign wake_evt = (mode_q == MODE_STOP) & (cs_rise | oc_wake);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oc_cnt_q <= 4'h0;
        end else if (clk_en) begin
            if (!oc_s || mode_q != MODE_STOP) begin
                oc_cnt_q <= 4'h0;
            end else if (tick && oc_cnt_q != 4'hF) begin
                oc_cnt_q <= oc_cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= MODE_RESET;
            sys_rst_n_q <= 1'b0;
            rst_cnt_q <= 16'h0000;
            wake_cnt_q <= 4'h0;
            stop_pend_q <= 1'b0;
        end else if (clk_en) begin
            if (accept && cmd[`CMD_ADDR_MSB:`CMD_ADDR_LSB] == `ADDR_STOP) begin
                stop_pend_q <= cmd[`STOP_GO_BIT];
            end
            case (mode_q)
                MODE_RESET: begin
                    if (tick) begin
                        rst_cnt_q <= rst_cnt_q + 16'h0001;
                    end
                    if (rst_cnt_q == 16'(HOLD)) begin
                        mode_q <= MODE_NORMAL;
                        sys_rst_n_q <= 1'b1;
                    end
                end
                MODE_NORMAL: begin
                    // stop waits for select to end so its own rise cannot wake
                    if (stop_pend_q && cs_s && tick) begin
                        mode_q <= MODE_STOP;
                        stop_pend_q <= 1'b0;
                    end
                end
                MODE_STOP: begin
                    if (wake_evt) begin
                        mode_q <= MODE_WAKE;
                        wake_cnt_q <= 4'h0;
                    end
                end
                MODE_WAKE: begin
                    if (tick) begin
                        wake_cnt_q <= wake_cnt_q + 4'h1;
                    end
                    if (wake_cnt_q == 4'(`WAKE_TICKS)) begin
                        mode_q <= MODE_NORMAL;
                    end
                end
                default: begin
                    mode_q <= MODE_RESET;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wake interrupt pulse and command turnaround guard
    logic int_n_q;
    logic [3:0] int_cnt_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            int_n_q <= 1'b1;
            int_cnt_q <= 4'h0;
        end else if (clk_en) begin
            if (wake_evt) begin
                int_n_q <= 1'b0;
                int_cnt_q <= 4'(`INT_PULSE_TICKS);
            end else if (tick && int_cnt_q != 4'h0) begin
                int_cnt_q <= int_cnt_q - 4'h1;
                if (int_cnt_q == 4'h1) begin
                    int_n_q <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            guard_q <= 4'h0;
        end else if (clk_en) begin
            if (wake_evt) begin
                guard_q <= 4'(`TURNAROUND_TICKS);
            end else if (tick && guard_q != 4'h0) begin
                guard_q <= guard_q - 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // can mode, slew and transmit path
    logic can_pend_q, pend_normal_q, can_dom_q, rxd_q;
    slew_t pend_slew_q;
    logic [7:0] dom_cnt_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            can_pend_q <= 1'b0;
            pend_normal_q <= 1'b0;
            pend_slew_q <= `SLEW_RESET;
            can_normal_q <= 1'b0;
            slew_q <= `SLEW_RESET;
        end else if (clk_en) begin
            if (accept && cmd[`CMD_ADDR_MSB:`CMD_ADDR_LSB] == `ADDR_CAN) begin
                can_pend_q <= 1'b1;
                pend_normal_q <= cmd[`CAN_NORMAL_BIT];
                pend_slew_q <= cmd[`SLEW_MSB:`SLEW_LSB];
            end else if (can_pend_q && tick) begin
                // next tick lands within one oscillator period of bit eight
                can_pend_q <= 1'b0;
                can_normal_q <= pend_normal_q;
                slew_q <= pend_slew_q;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dom_cnt_q <= 8'h00;
            timeout_q <= 1'b0;
        end else if (clk_en) begin
            if (txd_s) begin
                dom_cnt_q <= 8'h00;
                timeout_q <= 1'b0;
            end else if (tick && !timeout_q) begin
                dom_cnt_q <= dom_cnt_q + 8'h01;
                if (dom_cnt_q == 8'(`DOM_TIMEOUT_TICKS - 1)) begin
                    timeout_q <= 1'b1;
                end
            end
        end
    end

    // three-cycle path keeps 1 Mbit/s bits of 100 cycles intact
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            can_dom_q <= 1'b0;
            rxd_q <= 1'b1;
        end else if (clk_en) begin
            can_dom_q <= ~txd_s & ~timeout_q & can_normal_q;
            rxd_q <= ~bus_s;
        end
    end

    assign link.miso = miso_q;
    assign link.rxd = rxd_q;
    assign link.int_n = int_n_q;
    assign link.sys_rst_n = sys_rst_n_q;
    assign can_drive_dom = can_dom_q;
    assign can_normal = can_normal_q;
    assign can_slew = slew_q;
    assign mode = mode_q;

endmodule // sbc_device

// ==== sbc_host.sv ====
// host end: serial master with wake pulse and command spacing
// assumes the sbc answers on miso and int_n asynchronously to clk
`include "sbc_timing_defines.svh"

module sbc_host #(
    parameter int SCLK_HALF = `SCLK_HALF_CYC,
    parameter int WAKE_WAIT = `HOST_WAKE_WAIT_CYC,
    parameter int INT_WAIT = `HOST_INT_WAIT_CYC,
    parameter int MSG_GAP = `HOST_MSG_GAP_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // link to the sbc
    sbc_link_if.host link,
    // command port
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_data,
    output logic cmd_ready,
    output logic resp_valid,
    output logic [7:0] resp_data,
    input wire logic wake_req,
    // can controller side
    input wire logic can_tx,
    output logic can_rx
);
    import sbc_timing_pkg::*;

    // device needs three cycles to turn miso after a rising edge, and the host synchroniser two more
    if (SCLK_HALF < 8 || SCLK_HALF > 255 || WAKE_WAIT > 65535 || INT_WAIT > 65535
            || MSG_GAP > 65535 || MSG_GAP < 1) begin : g_bad_param
        $error("sbc_host: clock divider or wait counts out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic int_prev_q;
    logic int_fall;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= `HOST_SYNC_RESET;
            sync_q <= `HOST_SYNC_RESET;
            int_prev_q <= 1'b1;
        end else if (clk_en) begin
            meta_q <= {link.int_n, link.rxd, link.miso};
            sync_q <= meta_q;
            int_prev_q <= sync_q[2];
        end
    end

    assign int_fall = int_prev_q & ~sync_q[2];

    ////////////////////////////////////////////////////////////////////////
    // master sequencer
    host_state_t state_q;
    logic [7:0] half_q;
    logic [3:0] nbit_q;
    logic [7:0] sh_q;
    logic [7:0] rx_q;
    logic [15:0] gap_q;
    logic cs_n_q, sclk_q, mosi_q, ready_q, resp_valid_q;
    logic [7:0] resp_q;
    logic take, wake_go, half_done;

    assign take = cmd_valid & ready_q;
    assign wake_go = wake_req & (state_q == H_IDLE) & ~take;
    assign half_done = (half_q == 8'(SCLK_HALF - 1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= H_IDLE;
            half_q <= 8'h00;
            nbit_q <= 4'h0;
            sh_q <= 8'h00;
            rx_q <= 8'h00;
            cs_n_q <= 1'b1;
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
            resp_valid_q <= 1'b0;
            resp_q <= 8'h00;
        end else if (clk_en) begin
            resp_valid_q <= 1'b0;
            half_q <= (state_q == H_IDLE || half_done) ? 8'h00 : half_q + 8'h01;
            case (state_q)
                H_IDLE: begin
                    if (take) begin
                        state_q <= H_SHIFT;
                        cs_n_q <= 1'b0;
                        mosi_q <= cmd_data[7];
                        sh_q <= {cmd_data[6:0], 1'b0};
                        nbit_q <= 4'h0;
                    end else if (wake_go) begin
                        state_q <= H_WAKE;
                        cs_n_q <= 1'b0;
                    end
                end
                H_WAKE: begin
                    if (half_done) begin
                        cs_n_q <= 1'b1;
                        state_q <= H_IDLE;
                    end
                end
                H_SHIFT: begin
                    if (half_done && !sclk_q) begin
                        sclk_q <= 1'b1;
                        if (nbit_q != 4'h0) begin
                            mosi_q <= sh_q[7];
                            sh_q <= {sh_q[6:0], 1'b0};
                        end
                    end else if (half_done) begin
                        sclk_q <= 1'b0;
                        rx_q <= {rx_q[6:0], sync_q[0]};
                        nbit_q <= nbit_q + 4'h1;
                        if (nbit_q == 4'h7) begin
                            state_q <= H_END;
                        end
                    end
                end
                H_END: begin
                    if (half_done) begin
                        cs_n_q <= 1'b1;
                        resp_valid_q <= 1'b1;
                        resp_q <= rx_q;
                        state_q <= H_IDLE;
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end

    // one gap for every message is stricter than per register, but simple
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_q <= 16'h0000;
            ready_q <= 1'b0;
        end else if (clk_en) begin
            if (state_q == H_END && half_done) begin
                gap_q <= 16'(MSG_GAP);
            end else if (state_q == H_WAKE && half_done) begin
                gap_q <= 16'(WAKE_WAIT);
            end else if (int_fall && gap_q < 16'(INT_WAIT)) begin
                gap_q <= 16'(INT_WAIT);
            end else if (gap_q != 16'h0000) begin
                gap_q <= gap_q - 16'h0001;
            end
            ready_q <= (state_q == H_IDLE) & (gap_q == 16'h0000) & ~take & ~wake_go
                       & ~int_fall;
        end
    end

    logic txd_q, can_rx_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txd_q <= 1'b1;
            can_rx_q <= 1'b1;
        end else if (clk_en) begin
            txd_q <= can_tx;
            can_rx_q <= sync_q[1];
        end
    end

    assign link.cs_n = cs_n_q;
    assign link.sclk = sclk_q;
    assign link.mosi = mosi_q;
    assign link.txd = txd_q;
    assign cmd_ready = ready_q;
    assign resp_valid = resp_valid_q;
    assign resp_data = resp_q;
    assign can_rx = can_rx_q;

endmodule // sbc_host

// ==== sbc_link_chk.sv ====
// assertions on the link pins between the host end and the sbc end
// assumes ten core cycles per oscillator tick and a scaled reset hold
module sbc_link_chk #(
    parameter int HOLD_CYC = 50
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // link pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic miso,
    input wire logic int_n,
    input wire logic sys_rst_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////
    int cyc_q;
    // saturating, so a long run never wraps back under the hold
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cyc_q <= 0;
        end else if (cyc_q < 100000) begin
            cyc_q <= cyc_q + 1;
        end
    end
    // a short select pulse, far shorter than any message
    sequence wake_pulse;
        $rose(cs_n) && $past(cs_n, 12);
    endsequence
    ////////////////////////////////////////////////////////////
    AST_RST_HOLD: assert property ((cyc_q < HOLD_CYC) |-> !sys_rst_n)
        else $error("system reset released early");
    AST_RST_END: assert property ((cyc_q == HOLD_CYC + 10) |-> sys_rst_n)
        else $error("system reset held too long");
    AST_INT_WIDTH: assert property ($fell(int_n) |-> ##9 !int_n ##1 int_n)
        else $error("wake pulse not one tick wide");
    AST_INT_QUIET: assert property (!sys_rst_n |-> int_n)
        else $error("wake pulse during reset hold");
    AST_MISO_RISE: assert property ((!cs_n && !$past(cs_n, 6) && $changed(miso)) |-> sclk)
        else $error("reply bit moved outside clock high");
    AST_MISO_HOLD: assert property ((!cs_n && !sclk && !$past(sclk, 4) && !$past(cs_n, 6))
        |-> $stable(miso))
        else $error("reply bit moved while clock low");
    AST_WAKE_INT: assert property (wake_pulse |-> ##[1:30] !int_n)
        else $error("select wake gave no pulse");
    AST_WAKE_RST: assert property (wake_pulse |-> sys_rst_n [*8])
        else $error("system reset dropped on wake");
    ////////////////////////////////////////////////////////////
    cover property (wake_pulse ##[1:30] !int_n);
    cover property ($fell(cs_n) ##[100:200] $rose(cs_n));
    cover property ($rose(sys_rst_n));
endmodule // sbc_link_chk

// ==== test_sbc_mode_wake_timing.sv ====
// self-checking bench: host end and sbc end joined through one link
// assumes ten core cycles per oscillator tick, all device times scaled
module test_sbc_mode_wake_timing import sbc_timing_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_valid, cmd_ready, resp_valid, wake_req, can_tx, can_rx;
    logic oc, bus_dom, drive_dom, can_norm;
    logic run = 1'b1;
    logic [7:0] cmd_data, resp_data, resp;
    slew_t slew;
    sbc_mode_t mode;
    int errors, n_tests, cycles;
    sbc_link_if link();
    always #5 clk = ~clk;
    sbc_device #(.OSC_DIV(10), .RESET_TICKS(5)) i_sbc_device (.clk(clk), .reset_n(reset_n),
        .clk_en(run), .link(link), .vdd_overcurrent(oc), .bus_dominant(bus_dom),
        .can_drive_dom(drive_dom), .can_normal(can_norm), .can_slew(slew), .mode(mode));
    sbc_host #(.WAKE_WAIT(120), .INT_WAIT(40), .MSG_GAP(60)) i_sbc_host (.clk(clk),
        .reset_n(reset_n), .clk_en(run), .link(link), .cmd_valid(cmd_valid),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
        .resp_data(resp_data), .wake_req(wake_req), .can_tx(can_tx), .can_rx(can_rx));
    sbc_link_chk i_sbc_link_chk (.clk(clk), .reset_n(reset_n),
        .cs_n(link.cs_n), .sclk(link.sclk), .miso(link.miso), .int_n(link.int_n),
        .sys_rst_n(link.sys_rst_n));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic chk_mode(input sbc_mode_t m);
        check({6'h00, mode}, {6'h00, m});
    endtask
    // bounded, so a stuck handshake shows as a mismatch, not a hang
    task automatic wait_for(ref logic sig, input logic lvl, input int lim);
        int n = 0;
        while (sig !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        check({7'h00, sig}, {7'h00, lvl});
    endtask
    task automatic send(input logic [7:0] c);
        wait_for(cmd_ready, 1'b1, 300);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_data <= c;
        @(posedge clk);
        cmd_valid <= 1'b0;
        wait_for(resp_valid, 1'b1, 200);
        resp = resp_data;
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            errors++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        logic pn;
        slew_t ps;
        {cmd_valid, wake_req, oc, bus_dom} = 4'h0;
        can_tx = 1'b1;
        cmd_data = 8'h00;
        {errors, n_tests, cycles} = {32'h0, 32'h0, 32'h0};
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (40) @(posedge clk);
        check({7'h00, link.sys_rst_n}, 8'h00);
        wait_for(link.sys_rst_n, 1'b1, 40);
        repeat (2) @(negedge clk);
        chk_mode(MODE_NORMAL);
        check({6'h00, link.int_n, link.rxd}, 8'h03);
        $display("reset test done");
        pn = 1'b0;
        ps = 2'h3;
        for (int s = 0; s < 4; s++) begin
            send({5'h00, 2'(s), 1'(s)});
            check(resp, {1'b1, pn, ps, 4'h0});
            check({7'h00, cmd_ready}, 8'h00);
            repeat (5) @(negedge clk);
            check({6'h00, slew}, {6'h00, 2'(s)});
            check({7'h00, can_norm}, {7'h00, 1'(s)});
            pn = 1'(s);
            ps = 2'(s);
        end
        $display("command test done");
        @(posedge clk);
        can_tx <= 1'b0;
        bus_dom <= 1'b1;
        repeat (10) @(negedge clk);
        check({6'h00, drive_dom, can_rx}, 8'h02);
        repeat (180) @(negedge clk);
        check({7'h00, drive_dom}, 8'h01);
        // frozen short of the timeout: the count must not move
        @(posedge clk);
        run <= 1'b0;
        repeat (200) @(negedge clk);
        check({7'h00, drive_dom}, 8'h01);
        @(posedge clk);
        run <= 1'b1;
        repeat (210) @(negedge clk);
        check({7'h00, drive_dom}, 8'h00);
        repeat (100) @(negedge clk);
        check({7'h00, drive_dom}, 8'h00);
        @(posedge clk);
        can_tx <= 1'b1;
        repeat (10) @(posedge clk);
        can_tx <= 1'b0;
        repeat (10) @(negedge clk);
        check({7'h00, drive_dom}, 8'h01);
        @(posedge clk);
        can_tx <= 1'b1;
        bus_dom <= 1'b0;
        repeat (10) @(negedge clk);
        check({6'h00, drive_dom, can_rx}, 8'h01);
        $display("can test done");
        send(8'h41);
        check(resp, {1'b1, pn, ps, 4'h0});
        repeat (30) @(negedge clk);
        chk_mode(MODE_STOP);
        wait_for(cmd_ready, 1'b1, 100);
        @(posedge clk);
        wake_req <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
        wait_for(link.int_n, 1'b0, 40);
        check({7'h00, cmd_ready}, 8'h00);
        chk_mode(MODE_WAKE);
        repeat (60) @(negedge clk);
        check({5'h00, mode, link.sys_rst_n}, {5'h00, MODE_NORMAL, 1'b1});
        send(8'h07);
        check(resp, {1'b1, pn, ps, 4'h0});
        $display("select wake test done");
        send(8'h41);
        repeat (30) @(posedge clk);
        oc <= 1'b1;
        repeat (30) @(posedge clk);
        oc <= 1'b0;
        repeat (5) @(negedge clk);
        chk_mode(MODE_STOP);
        @(posedge clk);
        oc <= 1'b1;
        wait_for(link.int_n, 1'b0, 100);
        chk_mode(MODE_WAKE);
        @(posedge clk);
        oc <= 1'b0;
        repeat (5) @(negedge clk);
        send(8'h07);
        check(resp, {1'b1, pn, ps, 4'h4});
        $display("overcurrent wake test done");
        close_out();
    end
endmodule // test_sbc_mode_wake_timing
